// ---- verilog/irq_flags_map.svh ----
// register indices, bit positions and vectors for the interrupt and flag block
`ifndef IRQ_FLAGS_MAP_SVH
`define IRQ_FLAGS_MAP_SVH
`define IDX_PROCESSOR_FLAGS 8'h0A
`define IDX_IRQ_CONTROL_FIRST 8'h0B
`define IDX_IRQ_CONTROL_SECOND 8'h1E
`define IDX_FIFO_ACCESS_REQUEST 8'h21
`define IDX_HOST_LINK_CONTROL 8'h20
`define IDX_CORE_EVENT 8'h40
`define IDX_STACK_CONTROL 8'h41
`define FLAG_CARRY 0
`define FLAG_NIBBLE 1
`define FLAG_ZERO 2
`define FLAG_SIGNED_WRAP 3
`define FLAG_HALTED 4
`define FLAG_DOG 5
`define C1_GLOBAL 0
`define C1_HOST_LINK_EN 1
`define C1_TIMER_A_EN 2
`define C1_TIMER_B_EN 3
`define C1_HOST_LINK_PEND 4
`define C1_TIMER_A_PEND 5
`define C1_TIMER_B_PEND 6
`define C2_PLAY_EN 0
`define C2_SERIAL_EN 1
`define C2_CAPTURE_EN 2
`define C2_PLAY_PEND 4
`define C2_SERIAL_PEND 5
`define C2_CAPTURE_PEND 6
`define LINK_SUSPEND_BIT 0
`define LINK_RESUME_BIT 3
`define ARITH_MASK 8'h0F
`define FIRST_MASK 8'h7F
`define SECOND_MASK 8'h77
`define VEC_HOST_LINK 8'h04
`define VEC_TIMER_A 8'h08
`define VEC_TIMER_B 8'h0C
`define VEC_PLAY 8'h10
`define VEC_SERIAL 8'h14
`define VEC_CAPTURE 8'h18
`define STACK_DEPTH 5'h10
`endif

// ---- verilog/irq_flags_pkg.sv ----
// types for the interrupt and flag block
package irq_flags_pkg;
	typedef enum logic [1:0] {
		ALU_NONE,
		ALU_ADD,
		ALU_SUB,
		ALU_LOGIC
	} alu_op_t;
	typedef enum {
		SEQ_RUN,
		SEQ_HALTED
	} seq_state_t;
endpackage

// ---- verilog/irq_flags_ctrl.sv ----
// interrupt control and processor flag logic with an apb register port
//
// Implementation choice: the APB slave port.
`include "irq_flags_map.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_flags_ctrl (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic phase_two,
	input wire logic [1:0] alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic alu_carry_in,
	input wire logic rotate_valid,
	input wire logic rotate_carry,
	input wire logic halt_exec,
	input wire logic dog_clear_instruction,
	input wire logic dog_timeout,
	input wire logic return_from_irq,
	input wire logic stack_pop,
	input wire logic [4:0] fifo_access,
	input wire logic bus_suspend,
	input wire logic bus_resume,
	input wire logic bus_reset,
	input wire logic timer_a_overflow,
	input wire logic timer_b_overflow,
	input wire logic play_valid,
	input wire logic serial_done,
	input wire logic capture_valid,
	output logic [7:0] alu_result,
	output logic irq_call,
	output logic [7:0] irq_vector,
	output logic [4:0] stack_level,
	output logic halted,
	output logic wake
);
	logic [7:0] flags_reg;
	logic [7:0] first_reg;
	logic [7:0] second_reg;
	logic [7:0] fifo_access_request_reg;
	logic [7:0] host_link_control_reg;
	logic [4:0] stack_reg;
	logic [7:0] vector_reg;
	logic call_reg;
	irq_flags_pkg::seq_state_t state_reg;
	logic [7:0] result_reg;

	// sum with carries into bit 4, bit 7 and out of bit 7
	function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] lo;
		logic [3:0] mid;
		logic [1:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
		hi = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
		// carry out, nibble carry, msb carry-in xor carry-out, result
		add8 = {hi[1], lo[4], mid[3] ^ hi[1], hi[0], mid[2:0], lo[3:0]};
	endfunction

	logic wr_en;
	logic rd_en;
	logic [7:0] wbyte;
	assign wr_en = psel && penable && pwrite && pstrb[0];
	assign rd_en = psel && penable && !pwrite;
	assign wbyte = pwdata[7:0];
	assign pready = 1'b1;

	function automatic logic hit(input logic [7:0] idx, input logic [7:0] addr);
		hit = (addr == {idx[5:0], 2'b00});
	endfunction

	logic mapped;
	assign mapped = hit(`IDX_PROCESSOR_FLAGS, paddr) || hit(`IDX_IRQ_CONTROL_FIRST, paddr)
		|| hit(`IDX_IRQ_CONTROL_SECOND, paddr) || hit(`IDX_FIFO_ACCESS_REQUEST, paddr)
		|| hit(`IDX_HOST_LINK_CONTROL, paddr) || hit(`IDX_CORE_EVENT, paddr)
		|| hit(`IDX_STACK_CONTROL, paddr);
	assign pslverr = psel && penable && !mapped;

	// alu flag computation
	logic [10:0] sum;
	logic [7:0] opb;
	logic cin;
	logic [7:0] logic_res;
	always_comb begin
		opb = (alu_op == irq_flags_pkg::ALU_SUB) ? ~alu_b : alu_b;
		cin = (alu_op == irq_flags_pkg::ALU_SUB) ? 1'b1 : alu_carry_in;
		logic_res = alu_a & alu_b;
	end
	assign sum = add8(alu_a, opb, cin);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			result_reg <= 8'h00;
		end else if (alu_op == irq_flags_pkg::ALU_LOGIC) begin
			result_reg <= logic_res;
		end else if (alu_op != irq_flags_pkg::ALU_NONE) begin
			result_reg <= sum[7:0];
		end
	end
	assign alu_result = result_reg;

	// request selection
	logic [5:0] pend;
	logic [5:0] en;
	logic [5:0] ready_req;
	logic take;
	logic [2:0] pick;
	assign pend = {second_reg[`C2_CAPTURE_PEND], second_reg[`C2_SERIAL_PEND],
		second_reg[`C2_PLAY_PEND], first_reg[`C1_TIMER_B_PEND],
		first_reg[`C1_TIMER_A_PEND], first_reg[`C1_HOST_LINK_PEND]};
	assign en = {second_reg[`C2_CAPTURE_EN], second_reg[`C2_SERIAL_EN],
		second_reg[`C2_PLAY_EN], first_reg[`C1_TIMER_B_EN],
		first_reg[`C1_TIMER_A_EN], first_reg[`C1_HOST_LINK_EN]};
	assign ready_req = pend & en;
	assign take = phase_two && first_reg[`C1_GLOBAL] && (|ready_req)
		&& (stack_reg != `STACK_DEPTH);
	always_comb begin
		pick = 3'd0;
		for (int i = 5; i >= 0; i--) begin
			if (ready_req[i]) begin
				pick = 3'(i);
			end
		end
	end
	logic [5:0] ack;
	assign ack = take ? (6'h01 << pick) : 6'h00;

	// event sources
	logic link_event;
	assign link_event = (|fifo_access) || bus_suspend || bus_resume || bus_reset;

	logic fl_wr;
	logic c1_wr;
	logic c2_wr;
	logic fa_wr;
	logic lc_wr;
	logic sk_wr;
	assign fl_wr = wr_en && hit(`IDX_PROCESSOR_FLAGS, paddr);
	assign c1_wr = wr_en && hit(`IDX_IRQ_CONTROL_FIRST, paddr);
	assign c2_wr = wr_en && hit(`IDX_IRQ_CONTROL_SECOND, paddr);
	assign fa_wr = wr_en && hit(`IDX_FIFO_ACCESS_REQUEST, paddr);
	assign lc_wr = wr_en && hit(`IDX_HOST_LINK_CONTROL, paddr);
	assign sk_wr = wr_en && hit(`IDX_STACK_CONTROL, paddr);

	// first control register; event set wins over write and acknowledge
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			first_reg <= 8'h00;
		end else begin
			logic [7:0] n;
			n = first_reg;
			if (c1_wr) begin
				n = wbyte & `FIRST_MASK;
			end
			if (take) begin
				n[`C1_GLOBAL] = 1'b0;
			end
			if (return_from_irq) begin
				n[`C1_GLOBAL] = 1'b1;
			end
			if (ack[0]) n[`C1_HOST_LINK_PEND] = 1'b0;
			if (ack[1]) n[`C1_TIMER_A_PEND] = 1'b0;
			if (ack[2]) n[`C1_TIMER_B_PEND] = 1'b0;
			if (link_event) n[`C1_HOST_LINK_PEND] = 1'b1;
			if (timer_a_overflow) n[`C1_TIMER_A_PEND] = 1'b1;
			if (timer_b_overflow) n[`C1_TIMER_B_PEND] = 1'b1;
			first_reg <= n;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			second_reg <= 8'h00;
		end else begin
			logic [7:0] n;
			n = second_reg;
			if (c2_wr) begin
				n = wbyte & `SECOND_MASK;
			end
			if (ack[3]) n[`C2_PLAY_PEND] = 1'b0;
			if (ack[4]) n[`C2_SERIAL_PEND] = 1'b0;
			if (ack[5]) n[`C2_CAPTURE_PEND] = 1'b0;
			if (play_valid) n[`C2_PLAY_PEND] = 1'b1;
			if (serial_done) n[`C2_SERIAL_PEND] = 1'b1;
			if (capture_valid) n[`C2_CAPTURE_PEND] = 1'b1;
			second_reg <= n;
		end
	end

	// endpoint access bits; write 0 clears, set wins
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			fifo_access_request_reg <= 8'h00;
		end else begin
			fifo_access_request_reg <= ((fa_wr ? (fifo_access_request_reg & wbyte)
				: fifo_access_request_reg) | {3'b000, fifo_access});
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			host_link_control_reg <= 8'h00;
		end else begin
			logic [7:0] n;
			n = lc_wr ? wbyte : host_link_control_reg;
			if (bus_suspend) n[`LINK_SUSPEND_BIT] = 1'b1;
			if (bus_resume) n[`LINK_RESUME_BIT] = 1'b1;
			host_link_control_reg <= n;
		end
	end

	// processor flags
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			flags_reg <= 8'h00;
		end else begin
			logic [7:0] n;
			n = flags_reg;
			if (fl_wr) begin
				n = (flags_reg & ~`ARITH_MASK) | (wbyte & `ARITH_MASK);
			end
			if (alu_op == irq_flags_pkg::ALU_ADD || alu_op == irq_flags_pkg::ALU_SUB) begin
				n[`FLAG_CARRY] = sum[10];
				n[`FLAG_NIBBLE] = sum[9];
				n[`FLAG_ZERO] = (sum[7:0] == 8'h00);
				n[`FLAG_SIGNED_WRAP] = sum[8];
			end else if (alu_op == irq_flags_pkg::ALU_LOGIC) begin
				n[`FLAG_ZERO] = (logic_res == 8'h00);
			end
			if (rotate_valid) begin
				n[`FLAG_CARRY] = rotate_carry;
			end
			if (dog_clear_instruction) begin
				n[`FLAG_HALTED] = 1'b0;
				n[`FLAG_DOG] = 1'b0;
			end
			if (halt_exec) begin
				n[`FLAG_HALTED] = 1'b1;
				n[`FLAG_DOG] = 1'b0;
			end
			if (dog_timeout) begin
				n[`FLAG_DOG] = 1'b1;
			end
			flags_reg <= n;
		end
	end

	// stack level: only the program counter is pushed by a call
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stack_reg <= 5'h00;
		end else if (sk_wr) begin
			stack_reg <= wbyte[4:0];
		end else if (take && !stack_pop) begin
			stack_reg <= stack_reg + 5'h01;
		end else if (stack_pop && !take && stack_reg != 5'h00) begin
			stack_reg <= stack_reg - 5'h01;
		end
	end
	assign stack_level = stack_reg;

	function automatic logic [7:0] vec_of(input logic [2:0] p);
		case (p)
			3'd0: vec_of = `VEC_HOST_LINK;
			3'd1: vec_of = `VEC_TIMER_A;
			3'd2: vec_of = `VEC_TIMER_B;
			3'd3: vec_of = `VEC_PLAY;
			3'd4: vec_of = `VEC_SERIAL;
			default: vec_of = `VEC_CAPTURE;
		endcase
	endfunction

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			call_reg <= 1'b0;
			vector_reg <= 8'h00;
		end else begin
			call_reg <= take;
			if (take) begin
				vector_reg <= vec_of(pick);
			end
		end
	end
	assign irq_call = call_reg;
	assign irq_vector = vector_reg;

	// halt state and wake
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= irq_flags_pkg::SEQ_RUN;
		end else begin
			case (state_reg)
				irq_flags_pkg::SEQ_RUN: begin
					if (halt_exec) state_reg <= irq_flags_pkg::SEQ_HALTED;
				end
				irq_flags_pkg::SEQ_HALTED: begin
					if (|pend) state_reg <= irq_flags_pkg::SEQ_RUN;
				end
				default: state_reg <= irq_flags_pkg::SEQ_RUN;
			endcase
		end
	end
	assign halted = (state_reg == irq_flags_pkg::SEQ_HALTED);
	assign wake = halted && (|pend);

	// read data register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (hit(`IDX_PROCESSOR_FLAGS, paddr)) prdata[7:0] <= flags_reg;
			if (hit(`IDX_IRQ_CONTROL_FIRST, paddr)) prdata[7:0] <= first_reg;
			if (hit(`IDX_IRQ_CONTROL_SECOND, paddr)) prdata[7:0] <= second_reg;
			if (hit(`IDX_FIFO_ACCESS_REQUEST, paddr)) prdata[7:0] <= fifo_access_request_reg;
			if (hit(`IDX_HOST_LINK_CONTROL, paddr)) prdata[7:0] <= host_link_control_reg;
			if (hit(`IDX_CORE_EVENT, paddr)) prdata[7:0] <= {7'h00, halted};
			if (hit(`IDX_STACK_CONTROL, paddr)) prdata[7:0] <= {3'h0, stack_reg};
		end
	end
	logic unused_rd;
	assign unused_rd = rd_en;
endmodule
`default_nettype wire

// ---- tb/irq_flags_assertions.sv ----
// concurrent checks on the interrupt and flag block ports
`timescale 1ns/1ps
`default_nettype none
module irq_flags_assertions (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic phase_two,
	input wire logic [1:0] alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic stack_pop,
	input wire logic irq_call,
	input wire logic [7:0] irq_vector,
	input wire logic [7:0] alu_result,
	input wire logic [4:0] stack_level,
	input wire logic halted,
	input wire logic wake
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	property p_vec;
		irq_call |-> irq_vector inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	endproperty
	a_vec: assert property (p_vec) else $error("vector off table");
	property p_hold;
		irq_vector != $past(irq_vector) |-> irq_call;
	endproperty
	a_hold: assert property (p_hold) else $error("vector moved without call");
	property p_room;
		irq_call |-> $past(stack_level) < 5'h10;
	endproperty
	a_room: assert property (p_room) else $error("call on full stack");
	property p_push;
		irq_call && !$past(stack_pop) |-> stack_level == $past(stack_level) + 5'h01;
	endproperty
	a_push: assert property (p_push) else $error("stack not pushed once");
	property p_phase;
		irq_call |-> $past(phase_two);
	endproperty
	a_phase: assert property (p_phase) else $error("call off service edge");
	property p_wake;
		wake |-> halted;
	endproperty
	a_wake: assert property (p_wake) else $error("wake while running");
	property p_and;
		alu_op == 2'h3 |=> alu_result == $past(alu_a & alu_b);
	endproperty
	a_and: assert property (p_and) else $error("logic result wrong");
	property p_sub;
		alu_op == 2'h2 |=> alu_result == $past(alu_a - alu_b);
	endproperty
	a_sub: assert property (p_sub) else $error("sub result wrong");
	property p_rst;
		disable iff (1'b0) !nrst |=> stack_level == 5'h00 && !irq_call;
	endproperty
	a_rst: assert property (p_rst) else $error("reset left state");
	c_call: cover property (irq_call);
	c_full: cover property (stack_level == 5'h10);
	c_wake: cover property (wake);
endmodule
bind irq_flags_ctrl irq_flags_assertions chk (.*);
`default_nettype wire

// ---- tb/irq_event_source.sv ----
// model of the event sources and sequencer phase beside the block
`timescale 1ns/1ps
`default_nettype none
module irq_event_source (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ev_go,
	input wire logic [3:0] ev_code,
	output logic phase_two,
	output logic [4:0] fifo_access,
	output logic bus_suspend,
	output logic bus_resume,
	output logic bus_reset,
	output logic timer_a_overflow,
	output logic timer_b_overflow,
	output logic play_valid,
	output logic serial_done,
	output logic capture_valid
);
	logic [8:0] hit;
	assign hit = ev_go ? 9'h001 << ev_code : 9'h000;
	always_ff @(posedge core_clk) begin
		phase_two <= nrst & ~phase_two;
		bus_suspend <= hit[0];
		timer_a_overflow <= hit[1];
		timer_b_overflow <= hit[2];
		play_valid <= hit[3];
		serial_done <= hit[4];
		capture_valid <= hit[5];
		fifo_access <= {4'h0, hit[6]};
		bus_resume <= hit[7];
		bus_reset <= hit[8];
	end
endmodule
`default_nettype wire

// ---- tb/mcu_interrupt_and_status_flags_test.sv ----
// testbench for the interrupt and flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
 $display("[ERR] %s exp %h got %h", n, e, g); end end
`define PULSE(s) begin s <= 1'b1; @(posedge core_clk); s <= 1'b0; @(posedge core_clk); end
module mcu_interrupt_and_status_flags_test;
	typedef struct {logic [7:0] c1, c2, v; logic [3:0] ev;} row_t;
	localparam logic [7:0] a_fl = 8'h28, a_c1 = 8'h2C, a_c2 = 8'h78;
	localparam logic [7:0] a_lc = 8'h80, a_fa = 8'h84;
	logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, ev_go = 0;
	logic [7:0] paddr = 8'h00, alu_a = 8'h00, alu_b = 8'h00, alu_result, irq_vector;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'hF, ev_code = 4'h0;
	logic [1:0] alu_op = 2'h0;
	logic [4:0] fifo_access, stack_level;
	logic alu_carry_in = 0, rotate_valid = 0, rotate_carry = 0, halt_exec = 0;
	logic dog_clear_instruction = 0, dog_timeout = 0, return_from_irq = 0, stack_pop = 0;
	logic pready, pslverr, phase_two, err, bus_suspend, bus_resume, bus_reset, irq_call;
	logic timer_a_overflow, timer_b_overflow, play_valid, serial_done, capture_valid;
	logic halted, wake;
	int checks = 0, miscompares = 0, calls = 0, n;
	row_t rows [9] = '{'{8'h03, 8'h00, 8'h04, 4'h0}, '{8'h05, 8'h00, 8'h08, 4'h1},
		'{8'h09, 8'h00, 8'h0C, 4'h2}, '{8'h01, 8'h01, 8'h10, 4'h3},
		'{8'h01, 8'h02, 8'h14, 4'h4}, '{8'h01, 8'h04, 8'h18, 4'h5},
		'{8'h03, 8'h00, 8'h04, 4'h6}, '{8'h03, 8'h00, 8'h04, 4'h7},
		'{8'h03, 8'h00, 8'h04, 4'h8}};
	irq_flags_ctrl DUT (.*);
	irq_event_source src (.*);
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (irq_call === 1'b1) calls++;
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic fire(input logic [3:0] c);
		ev_code <= c;
		ev_go <= 1'b1;
		@(posedge core_clk);
		ev_go <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wait_for(ref logic s, input logic v);
		int t;
		t = 0;
		while (s !== v && t < 20) begin
			@(posedge core_clk);
			t++;
		end
	endtask
	task automatic alu(input logic [1:0] op, input logic [7:0] a, input logic [7:0] b);
		alu_op <= op;
		alu_a <= a;
		alu_b <= b;
		@(posedge core_clk);
		alu_op <= 2'h0;
		apb(0, a_fl, 8'h00);
	endtask
	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		apb(0, a_c1, 8'h00);
		`CHK("first", 8'h00, r[7:0])
		apb(0, a_c2, 8'h00);
		`CHK("second", 8'h00, r[7:0])
		apb(0, 8'h10, 8'h00);
		`CHK("unmapped", 1'b1, err)
		apb(1, a_fl, 8'hFF);
		apb(0, a_fl, 8'h00);
		`CHK("flags", 8'h0F, r[7:0])
		`PULSE(dog_timeout)
		apb(0, a_fl, 8'h00);
		`CHK("dog", 2'b10, r[5:4])
		`PULSE(halt_exec)
		`CHK("halted", 1'b1, halted)
		`CHK("no wake", 1'b0, wake)
		apb(0, a_fl, 8'h00);
		`CHK("halt flags", 2'b01, r[5:4])
		fire(4'h1);
		wait_for(halted, 1'b0);
		`CHK("woken", 1'b0, halted)
		apb(1, a_c1, 8'h00);
		`PULSE(dog_timeout)
		apb(1, a_fl, 8'h00);
		apb(0, a_fl, 8'h00);
		`CHK("kept", 8'h30, r[7:0])
		`PULSE(dog_clear_instruction)
		apb(0, a_fl, 8'h00);
		`CHK("cleared", 2'b00, r[5:4])
		alu(irq_flags_pkg::ALU_ADD, 8'h8F, 8'h71);
		`CHK("add", 4'h7, r[3:0])
		alu(irq_flags_pkg::ALU_SUB, 8'h80, 8'h01);
		`CHK("sub", 4'h9, r[3:0])
		`CHK("sub res", 8'h7F, alu_result)
		alu(irq_flags_pkg::ALU_LOGIC, 8'h0F, 8'hF0);
		`CHK("zero", 1'b1, r[2])
		`PULSE(rotate_valid)
		apb(0, a_fl, 8'h00);
		`CHK("rotate", 1'b0, r[0])
		foreach (rows[i]) begin
			apb(1, a_c2, rows[i].c2);
			apb(1, a_c1, rows[i].c1);
			fire(rows[i].ev);
			wait_for(irq_call, 1'b1);
			`CHK("vector", rows[i].v, irq_vector)
			apb(0, a_c1, 8'h00);
			`CHK("first", rows[i].c1 & 8'hFE, r[7:0])
			apb(0, a_c2, 8'h00);
			`CHK("second", rows[i].c2, r[7:0])
		end
		apb(0, a_lc, 8'h00);
		`CHK("link", 2'b11, {r[3], r[0]})
		apb(0, a_fa, 8'h00);
		`CHK("fifo", 1'b1, r[0])
		apb(1, a_fa, 8'h00);
		apb(0, a_fa, 8'h00);
		`CHK("fifo clr", 1'b0, r[0])
		`PULSE(stack_pop)
		apb(0, a_c1, 8'h00);
		`CHK("ret", 1'b0, r[0])
		`PULSE(return_from_irq)
		apb(0, a_c1, 8'h00);
		`CHK("return_from_irq", 1'b1, r[0])
		apb(1, a_c1, 8'h00);
		for (int k = 5; k >= 0; k--) fire(k[3:0]);
		apb(1, a_c2, 8'h77);
		apb(0, a_c1, 8'h00);
		`CHK("latched", 8'h70, r[7:0])
		apb(1, a_c1, 8'h7F);
		for (int k = 0; k < 6; k++) begin
			wait_for(irq_call, 1'b1);
			`CHK("order", 8'h04 + 8'(4 * k), irq_vector)
			apb(0, a_c1, 8'h00);
			apb(1, a_c1, r[7:0] | 8'h01);
		end
		while (stack_level !== 5'h10 && calls < 60) begin
			apb(1, a_c1, 8'h05);
			fire(4'h1);
			wait_for(irq_call, 1'b1);
		end
		apb(1, a_c1, 8'h05);
		fire(4'h1);
		n = calls;
		repeat (8) @(posedge core_clk);
		`CHK("held", n, calls)
		`PULSE(stack_pop)
		wait_for(irq_call, 1'b1);
		`CHK("after pop", 8'h08, irq_vector)
		`CHK("stack", 5'h10, stack_level)
		summarize();
	end
endmodule
`default_nettype wire
